// file: core/mic_decimator_pkg.sv
// package for the microphone decimator: register map, field layout, reset values and widths
// assumes a 32-bit classic wishbone slave port, byte addresses, one register per aligned word
package mic_decimator_pkg;

   // system clock and the reference figures of the documented setup
   localparam int unsigned CLK_FREQ_HZ         = 40_000_000;
   localparam int unsigned CLK_PERIOD_NS       = 25;
   localparam int unsigned DOC_SOURCE_CLOCK_HZ = 16_384_000;
   localparam int unsigned DOC_SAMPLE_RATE_SPS = 8_000;

   // data path widths and depths
   localparam int unsigned SAMPLE_WIDTH = 16;
   localparam int unsigned CIC_ORDER    = 3;
   localparam int unsigned CIC_WIDTH    = 26;
   localparam int unsigned HPF_WIDTH    = 34;
   localparam int unsigned FIFO_DEPTH   = 256;
   localparam int unsigned FIFO_AW      = 8;
   localparam int unsigned CIC_FULL_SCALE_LOG2 = 15;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_CLKDIV     = 8'h04;
   localparam logic [7:0] ADDR_DECIM      = 8'h08;
   localparam logic [7:0] ADDR_TRIGGER    = 8'h0c;
   localparam logic [7:0] ADDR_FIFO_DATA  = 8'h10;
   localparam logic [7:0] ADDR_FIFO_COUNT = 8'h14;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
   localparam logic [7:0] ADDR_INT_CLEAR  = 8'h1c;
   localparam logic [7:0] ADDR_INT_ENABLE = 8'h20;

   // control register fields
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_HPF_BIT    = 1;
   localparam int unsigned CTRL_HPF_K_LSB  = 8;
   localparam int unsigned CTRL_HPF_K_MSB  = 11;
   // clock divisor fields
   localparam int unsigned DIV1_LSB = 0;
   localparam int unsigned DIV2_LSB = 8;
   localparam int unsigned DIV3_LSB = 16;
   // interrupt bits
   localparam int unsigned INT_TRIGGER_BIT   = 0;
   localparam int unsigned INT_OVERFLOW_BIT  = 1;
   localparam int unsigned INT_UNDERFLOW_BIT = 2;
   localparam int unsigned INT_BITS          = 3;

   // reset values: 8 ksps from a 16.384 MHz source with divisors 4,1,3 and rate 64
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0502;
   localparam logic [7:0]  DIV1_RESET    = 8'h04;
   localparam logic [7:0]  DIV2_RESET    = 8'h01;
   localparam logic [7:0]  DIV3_RESET    = 8'h03;
   localparam logic [6:0]  DECIM_RESET   = 7'h40;
   localparam logic [8:0]  TRIGGER_RESET = 9'h080;
   localparam logic [2:0]  INT_EN_RESET  = 3'h0;

endpackage : mic_decimator_pkg

// file: core/mic_clock_gen.sv
// microphone clock generator: divides the system clock by div1 * div2 * (div3 + 1)
// assumes divisors held stable while running; a product below 2 is raised to 2
`timescale 1ns/100ps
`default_nettype none

module mic_clock_gen (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       enable_i,
   input  wire logic [7:0] div1_i,
   input  wire logic [7:0] div2_i,
   input  wire logic [7:0] div3_i,
   output var  logic       mic_clk_o,
   output var  logic       rise_o,
   output var  logic       fall_o
);

   logic [15:0] prod12;
   logic [8:0]  div3_plus;
   logic [24:0] period_raw;
   logic [24:0] period;
   logic [24:0] half;
   logic [24:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////////////
   // division ratio; zero divisors would stall the counter, so clamp to 2
   assign prod12     = div1_i * div2_i;
   assign div3_plus  = {1'b0, div3_i} + 9'h001;
   assign period_raw = prod12 * div3_plus;
   assign period     = (period_raw < 25'h0000002) ? 25'h0000002 : period_raw;
   assign half       = period >> 1;

   ////////////////////////////////////////////////////////////////////////////
   // divided clock counter
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         cnt_reg   <= 25'h0000000;
         mic_clk_o <= 1'b0;
         rise_o    <= 1'b0;
         fall_o    <= 1'b0;
      end else begin
         rise_o <= 1'b0;
         fall_o <= 1'b0;
         if (cnt_reg >= period - 25'h0000001) begin
            cnt_reg   <= 25'h0000000;
            mic_clk_o <= 1'b1;
            rise_o    <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg + 25'h0000001;
            // no fall strobe before the first rise, or a stale bit would be taken
            if (cnt_reg == half - 25'h0000001 && mic_clk_o) begin
               mic_clk_o <= 1'b0;
               fall_o    <= 1'b1;
            end
         end
      end
   end

   // helper: cycles between rising edges
   logic [24:0] gap_reg;
   logic        seen_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         gap_reg  <= 25'h0000000;
         seen_reg <= 1'b0;
      end else if (rise_o) begin
         gap_reg  <= 25'h0000001;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 25'h0000001;
      end
   end

   AST_MIC_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
      (rise_o && seen_reg && $stable(period)) |-> (gap_reg == period))
      else $error("mic clock period differs from divisor product");

endmodule : mic_clock_gen

`default_nettype wire

// file: core/sample_fifo.sv
// sample fifo: first-word-fall-through buffer of pcm samples with an occupancy count
// a pop from an empty fifo and a push into a full fifo are both dropped
`timescale 1ns/100ps
`default_nettype none

module sample_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 256,
   parameter int unsigned AW    = 8
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          push_i,
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic          pop_i,
   output var  logic [WIDTH-1:0] data_o,
   output var  logic [AW:0]   count_o,
   output var  logic          full_o,
   output var  logic          empty_o
);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic             do_push;
   logic             do_pop;

   // depth needs one bit more than the pointers, so size the constant to the count
   assign full_o  = (count_o == (AW+1)'(DEPTH));
   assign empty_o = (count_o == '0);
   assign do_push = push_i && !full_o;
   assign do_pop  = pop_i && !empty_o;
   assign data_o  = mem[rd_ptr_reg];

   ////////////////////////////////////////////////////////////////////////////
   // storage array, no reset needed
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= data_i;
      end
   end

   // pointers and count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_o    <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         if (do_push && !do_pop) begin
            count_o <= count_o + (AW+1)'(1);
         end else if (do_pop && !do_push) begin
            count_o <= count_o - (AW+1)'(1);
         end
      end
   end

endmodule : sample_fifo

`default_nettype wire

// file: core/mic_decimator.sv
// microphone decimator top: clock out, bitstream capture, cic decimation, dc removal, fifo, wishbone
// assumes a single-bit microphone answering on mic_bitstream_in_i, asynchronous to clk_i
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module mic_decimator (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic        mic_bitstream_in_i,
   output var  logic        mic_clock_out_o,
   output var  logic        sample_ready_irq_o
);
   import mic_decimator_pkg::*;

   // configuration and status
   logic [31:0] ctrl_reg;
   logic [7:0]  div1_reg, div2_reg, div3_reg;
   logic [6:0]  decim_reg;
   logic [8:0]  trigger_reg;
   logic [2:0]  int_status_reg;
   logic [2:0]  int_enable_reg;
   logic [2:0]  int_set;
   logic        enable;
   logic        hpf_on;
   logic [3:0]  hpf_k;
   // bus
   logic        bus_req;
   logic        bus_wr;
   logic        bus_rd;
   logic [31:0] rd_data;
   // capture and cic
   logic        bit_meta_reg, bit_sync_reg;
   logic        mic_rise, mic_fall;
   logic signed [CIC_WIDTH-1:0] integ_reg [0:CIC_ORDER-1];
   logic signed [CIC_WIDTH-1:0] dly_reg   [0:CIC_ORDER-1];
   logic signed [CIC_WIDTH-1:0] comb      [0:CIC_ORDER-1];
   logic signed [CIC_WIDTH-1:0] bit_value;
   logic signed [CIC_WIDTH-1:0] cic_reg;
   logic        cic_valid_reg;
   logic [7:0]  dec_cnt_reg;
   logic [7:0]  dec_total;
   logic [4:0]  shift;
   // filter and output
   logic signed [HPF_WIDTH-1:0] x_now, x_prev_reg, y_reg, y_next;
   logic [15:0] cic_scaled;
   logic [15:0] sample_reg;
   logic        sample_valid_reg;
   logic [15:0] fifo_head;
   logic [FIFO_AW:0] fifo_count;
   logic        fifo_full, fifo_empty, fifo_pop;

   assign enable = ctrl_reg[CTRL_ENABLE_BIT];
   assign hpf_on = ctrl_reg[CTRL_HPF_BIT];
   assign hpf_k  = ctrl_reg[CTRL_HPF_K_MSB:CTRL_HPF_K_LSB];

   // byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // cic gain is m^3; shift by 3*ceil(log2 m) minus the 16-bit full scale
   function automatic logic [4:0] gain_shift(input logic [7:0] m);
      logic [3:0] lg;
      int         t;
      lg = 4'h0;
      for (int i = 0; i < 8; i++) begin
         if (m > (8'h01 << i)) begin
            lg = 4'(i + 1);
         end
      end
      t = 3 * int'(lg) - int'(CIC_FULL_SCALE_LOG2);
      return (t < 0) ? 5'h00 : 5'(t);
   endfunction

   // saturate a wide signed value into 16 bits
   function automatic logic [15:0] sat16(input logic signed [HPF_WIDTH-1:0] v);
      if (v > HPF_WIDTH'(32767)) begin
         return 16'h7fff;
      end else if (v < -HPF_WIDTH'(32768)) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave: ack one cycle after the request, dropped the cycle after
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr  = bus_req && wb_we_i;
   assign bus_rd  = bus_req && !wb_we_i;

   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         ADDR_CTRL:       rd_data = ctrl_reg;
         ADDR_CLKDIV:     rd_data = {8'h00, div3_reg, div2_reg, div1_reg};
         ADDR_DECIM:      rd_data = {25'h0000000, decim_reg};
         ADDR_TRIGGER:    rd_data = {23'h000000, trigger_reg};
         ADDR_FIFO_DATA:  rd_data = fifo_empty ? 32'h0000_0000 : {{16{fifo_head[15]}}, fifo_head};
         ADDR_FIFO_COUNT: rd_data = {23'h000000, fifo_count};
         ADDR_INT_STATUS: rd_data = {29'h00000000, int_status_reg};
         ADDR_INT_ENABLE: rd_data = {29'h00000000, int_enable_reg};
         default:         rd_data = 32'h0000_0000;
      endcase
   end

   // answer and read data register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_rd) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // configuration registers, written through byte lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg       <= CTRL_RESET;
         div1_reg       <= DIV1_RESET;
         div2_reg       <= DIV2_RESET;
         div3_reg       <= DIV3_RESET;
         decim_reg      <= DECIM_RESET;
         trigger_reg    <= TRIGGER_RESET;
         int_enable_reg <= INT_EN_RESET;
      end else if (bus_wr) begin
         case (wb_adr_i)
            ADDR_CTRL:       ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_0f03;
            ADDR_CLKDIV:     {div3_reg, div2_reg, div1_reg} <=
                                24'(merge({8'h00, div3_reg, div2_reg, div1_reg}, wb_dat_i, wb_sel_i));
            ADDR_DECIM:      decim_reg <= 7'(merge({25'h0000000, decim_reg}, wb_dat_i, wb_sel_i));
            ADDR_TRIGGER:    trigger_reg <= 9'(merge({23'h000000, trigger_reg}, wb_dat_i, wb_sel_i));
            ADDR_INT_ENABLE: int_enable_reg <= 3'(merge({29'h00000000, int_enable_reg}, wb_dat_i, wb_sel_i));
            default:         ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: sticky status, set wins over a clear in the same cycle
   assign fifo_pop = bus_rd && (wb_adr_i == ADDR_FIFO_DATA) && !fifo_empty;
   always_comb begin
      int_set = 3'h0;
      int_set[INT_TRIGGER_BIT]   = enable && (fifo_count >= {1'b0, trigger_reg});
      int_set[INT_OVERFLOW_BIT]  = sample_valid_reg && fifo_full;
      int_set[INT_UNDERFLOW_BIT] = bus_rd && (wb_adr_i == ADDR_FIFO_DATA) && fifo_empty;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_status_reg     <= 3'h0;
         sample_ready_irq_o <= 1'b0;
      end else begin
         if (bus_wr && wb_adr_i == ADDR_INT_CLEAR && wb_sel_i[0]) begin
            int_status_reg <= (int_status_reg & ~wb_dat_i[2:0]) | int_set;
         end else begin
            int_status_reg <= int_status_reg | int_set;
         end
         sample_ready_irq_o <= |(int_status_reg & int_enable_reg);
      end
   end

   AST_IRQ_TRIGGER: assert property (@(posedge clk_i) disable iff (rst_i)
      (int_set[INT_TRIGGER_BIT] && int_enable_reg[INT_TRIGGER_BIT] && !bus_wr) |-> ##2 sample_ready_irq_o)
      else $error("trigger level reached but interrupt not raised");

   ////////////////////////////////////////////////////////////////////////////
   // microphone clock out, driven straight from the generator's mic_clk_o flop
   mic_clock_gen u_clock (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .enable_i  (enable),
      .div1_i    (div1_reg),
      .div2_i    (div2_reg),
      .div3_i    (div3_reg),
      .mic_clk_o (mic_clock_out_o),
      .rise_o    (mic_rise),
      .fall_o    (mic_fall)
   );

   // two-flop synchroniser on the microphone data pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_meta_reg <= 1'b0;
         bit_sync_reg <= 1'b0;
      end else begin
         bit_meta_reg <= mic_bitstream_in_i;
         bit_sync_reg <= bit_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cic integrators; the bit is taken only at the falling edge, the left slot
   assign bit_value = bit_sync_reg ? CIC_WIDTH'(1) : -CIC_WIDTH'(1);
   assign dec_total = {decim_reg, 1'b0};
   assign shift     = gain_shift(dec_total);

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) begin
         for (int i = 0; i < CIC_ORDER; i++) begin
            integ_reg[i] <= '0;
         end
         dec_cnt_reg <= 8'h00;
      end else if (mic_fall) begin
         integ_reg[0] <= integ_reg[0] + bit_value;
         for (int i = 1; i < CIC_ORDER; i++) begin
            integ_reg[i] <= integ_reg[i] + integ_reg[i-1];
         end
         dec_cnt_reg <= (dec_cnt_reg >= dec_total - 8'h01) ? 8'h00 : dec_cnt_reg + 8'h01;
      end
   end

   // comb chain at the decimated rate
   always_comb begin
      comb[0] = integ_reg[CIC_ORDER-1] - dly_reg[0];
      for (int i = 1; i < CIC_ORDER; i++) begin
         comb[i] = comb[i-1] - dly_reg[i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) begin
         for (int i = 0; i < CIC_ORDER; i++) begin
            dly_reg[i] <= '0;
         end
         cic_reg       <= '0;
         cic_valid_reg <= 1'b0;
      end else begin
         cic_valid_reg <= mic_fall && (dec_cnt_reg >= dec_total - 8'h01);
         if (mic_fall && (dec_cnt_reg >= dec_total - 8'h01)) begin
            dly_reg[0] <= integ_reg[CIC_ORDER-1];
            for (int i = 1; i < CIC_ORDER; i++) begin
               dly_reg[i] <= comb[i-1];
            end
            cic_reg <= comb[CIC_ORDER-1];
         end
      end
   end

   // helper: microphone bits between decimated outputs
   logic [8:0] bits_seen_reg;
   logic       first_out_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) begin
         bits_seen_reg <= 9'h000;
         first_out_reg <= 1'b1;
      end else if (cic_valid_reg) begin
         bits_seen_reg <= {8'h00, mic_fall};
         first_out_reg <= 1'b0;
      end else begin
         bits_seen_reg <= bits_seen_reg + {8'h00, mic_fall};
      end
   end

   AST_DECIM_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
      (cic_valid_reg && !first_out_reg && $stable(decim_reg)) |-> (bits_seen_reg == {1'b0, dec_total}))
      else $error("decimated sample not after twice the rate in bits");

   AST_EDGE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      (enable && $past(enable) && !$stable(integ_reg[0])) |-> $past(mic_fall))
      else $error("bitstream captured off the falling edge");

   ////////////////////////////////////////////////////////////////////////////
   // scale to 16 bits, then optional dc blocker y = x - x1 + y1 - y1/2^k
   assign cic_scaled = sat16(HPF_WIDTH'(cic_reg >>> shift));
   assign x_now      = HPF_WIDTH'($signed(cic_scaled));
   assign y_next     = x_now - x_prev_reg + y_reg - (y_reg >>> hpf_k);

   always_ff @(posedge clk_i) begin
      if (rst_i || !enable) begin
         x_prev_reg       <= '0;
         y_reg            <= '0;
         sample_reg       <= 16'h0000;
         sample_valid_reg <= 1'b0;
      end else begin
         sample_valid_reg <= cic_valid_reg;
         if (cic_valid_reg) begin
            x_prev_reg <= x_now;
            y_reg      <= y_next;
            sample_reg <= hpf_on ? sat16(y_next) : cic_scaled;
         end
      end
   end

   sequence s_cic_out;
      cic_valid_reg ##1 sample_valid_reg;
   endsequence

   AST_WORD_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
      (cic_valid_reg && !hpf_on && enable) |-> s_cic_out ##0 (sample_reg == $past(cic_scaled)))
      else $error("pcm word does not follow the decimator output");

   AST_HPF_DC: assert property (@(posedge clk_i) disable iff (rst_i)
      (cic_valid_reg && hpf_on && enable && x_now == x_prev_reg) |->
         ((y_reg >= 0) ? (y_next >= 0 && y_next <= y_reg) : (y_next <= 0 && y_next >= y_reg)))
      else $error("high-pass filter output grows on a constant input");

   ////////////////////////////////////////////////////////////////////////////
   // sample buffer for software
   sample_fifo #(
      .WIDTH (SAMPLE_WIDTH),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .push_i  (sample_valid_reg),
      .data_i  (sample_reg),
      .pop_i   (fifo_pop),
      .data_o  (fifo_head),
      .count_o (fifo_count),
      .full_o  (fifo_full),
      .empty_o (fifo_empty)
   );

   sequence s_bus_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   AST_BUS_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req |=> s_bus_answer)
      else $error("wishbone ack not a single cycle after request");

   AST_FIFO_POP: assert property (@(posedge clk_i) disable iff (rst_i)
      (fifo_pop && !sample_valid_reg) |=> (fifo_count == $past(fifo_count) - 9'h001))
      else $error("fifo read did not remove a sample");

endmodule : mic_decimator

`default_nettype wire

// file: sim/mic_model.sv
// single-bit microphone model: answers on the mic clock with a chosen bit pattern
// assumes the converter samples on the falling edge; the other half carries junk
`timescale 1ns/100ps
`default_nettype none

module mic_model (
   input  wire logic       mic_clk_i,
   input  wire logic [1:0] mode_i,
   output var  logic       data_o
);
   initial data_o = 1'b0;
   // drive a valid bit after each rise: 1 = all ones, 2 = random, else zero
   always @(posedge mic_clk_i) begin
      data_o <= (mode_i == 2'h1) ? 1'b1 : (mode_i == 2'h2) ? 1'($urandom) : 1'b0;
   end
   // released after the fall: the inverse shows, so a wrong-edge sampler reads junk
   always @(negedge mic_clk_i) begin
      data_o <= ~data_o;
   end
endmodule // mic_model
`default_nettype wire

// file: sim/tb_pdm_to_pcm_decimator.sv
// testbench for the microphone decimator: wishbone master, read checker, mic model
// assumes the register map of the package and a 40 MHz clock
`timescale 1ns/100ps
`default_nettype none

module tb_pdm_to_pcm_decimator;
   import mic_decimator_pkg::*;
   typedef struct {logic [31:0] m; logic [31:0] e; bit a;} note_type;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mprev = 0;
   logic [7:0]  adr = 0;
   logic [31:0] wdat = 0, rdat;
   logic        ack, mclk, irq, bit_in;
   logic [1:0]  mode = 0;
   int          bad_count = 0, cmp_count = 0, ticks = 0, per = 0, last = 0, n;
   note_type    q[$], t;

   initial forever #12.5 clk_i = ~clk_i;

   mic_decimator i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .mic_bitstream_in_i(bit_in), .mic_clock_out_o(mclk), .sample_ready_irq_o(irq));
   mic_model i_mic (.mic_clk_i(mclk), .mode_i(mode), .data_o(bit_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("Error value exp %h seen %h at %0d", e, s, ticks);
      end
   endtask
   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one classic cycle; a read leaves its expectation for the watcher
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input bit ab);
      if (!w) q.push_back('{m, e, ab});
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      do @(posedge clk_i); while (!ack);
      cyc <= 0; stb <= 0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(a, 1, d, 0, 0, 0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input bit ab);
      wb(a, 0, 0, m, e, ab);
   endtask
   // run the converter for a number of cycles, checking the mic clock period
   task automatic run(input logic [31:0] c, input int cycles);
      per <= 8;
      wr(ADDR_CTRL, c);
      repeat (cycles) @(posedge clk_i);
      wr(ADDR_CTRL, 0);
      per <= 0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // read watcher (abs option for values that only need to be small) and timeout
   always @(posedge clk_i) begin
      ticks <= ticks + 1;
      if (ack && !we && q.size() > 0) begin
         t = q.pop_front();
         chk(((t.a && rdat[31]) ? -rdat : rdat) & t.m, t.e);
      end
      if (ticks > 20000) begin
         bad_count++;
         finish_test();
      end
   end
   always @(posedge clk_i) begin
      mprev <= mclk;
      if (per == 0) last <= 0;
      else if (mclk && !mprev) begin
         if (last != 0) chk(32'(ticks - last), 32'(per));
         last <= ticks;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h6dccb682));
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rd(ADDR_CTRL, '1, CTRL_RESET, 0);
      rd(ADDR_CLKDIV, '1, 32'h00030104, 0);
      rd(ADDR_DECIM, '1, 32'h40, 0);
      rd(ADDR_TRIGGER, '1, 32'h80, 0);
      rd(ADDR_INT_ENABLE, '1, 0, 0);
      rd(8'h30, '1, 0, 0);
      $display("reset values done");
      // period 2*1*(3+1) = 8, rate 4: one sample per 64 cycles
      mode <= 2;
      wr(ADDR_CLKDIV, 32'h00030102);
      wr(ADDR_DECIM, 4);
      run(1, 20 * 64 + 32);
      rd(ADDR_FIFO_COUNT, '1, 20, 0);
      repeat (20) rd(ADDR_FIFO_DATA, 0, 0, 0);
      $display("clock and rate done");
      // all ones, filter off, 2R = 8: settled cic output is 8^3 with no shift
      mode <= 1;
      run(1, 10 * 64 + 32);
      rd(ADDR_FIFO_COUNT, '1, 10, 0);
      repeat (9) rd(ADDR_FIFO_DATA, 0, 0, 0);
      rd(ADDR_FIFO_DATA, '1, 32'h00000200, 0);
      $display("full scale done");
      // filter on with shift 2: constant input decays toward zero
      run(32'h203, 48 * 64 + 32);
      rd(ADDR_FIFO_COUNT, '1, 48, 0);
      repeat (47) rd(ADDR_FIFO_DATA, 0, 0, 0);
      rd(ADDR_FIFO_DATA, 32'hfffffff8, 0, 1);
      $display("dc removal done");
      // trigger at 4, enabled: irq near the fourth sample, sticky, masked, cleared
      wr(ADDR_TRIGGER, 4);
      wr(ADDR_INT_CLEAR, 7);
      wr(ADDR_INT_ENABLE, 1);
      per <= 8;
      wr(ADDR_CTRL, 1);
      n = 0;
      while (!irq && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(n >= 192 && n < 400), 1);
      rd(ADDR_FIFO_COUNT, '1, 4, 0);
      rd(ADDR_INT_STATUS, 1, 1, 0);
      wr(ADDR_INT_CLEAR, 1);
      rd(ADDR_INT_STATUS, 1, 1, 0);
      wr(ADDR_INT_ENABLE, 0);
      wr(ADDR_CTRL, 0);
      per <= 0;
      @(posedge clk_i);
      chk(32'(irq), 0);
      repeat (4) rd(ADDR_FIFO_DATA, 0, 0, 0);
      wr(ADDR_INT_CLEAR, 7);
      rd(ADDR_FIFO_DATA, '1, 0, 0);
      rd(ADDR_INT_STATUS, 7, 4, 0);
      wr(ADDR_INT_ENABLE, 4);
      repeat (3) @(posedge clk_i);
      chk(32'(irq), 1);
      wr(ADDR_INT_CLEAR, 4);
      repeat (3) @(posedge clk_i);
      chk(32'(irq), 0);
      $display("interrupt done");
      finish_test();
   end
endmodule // tb_pdm_to_pcm_decimator
`default_nettype wire
